/* common/lcc_map.svh */
`ifndef LCC_MAP_SVH
`define LCC_MAP_SVH

// register byte offsets
`define LCC_OFS_FAIRNESS      8'hdc
`define LCC_OFS_LINK_SET      8'he0
`define LCC_OFS_LINK_CLEAR    8'he4
`define LCC_OFS_TIMER_STATUS  8'hf0

// fairness limit field
`define LCC_FAIR_LIMIT_LSB    0
`define LCC_FAIR_LIMIT_W      8
`define LCC_FAIR_LIMIT_RST    8'h00

// link control flag positions
`define LCC_BIT_EXT_ROLLOVER  22
`define LCC_BIT_CYCLE_MASTER  21
`define LCC_BIT_COUNTER_RUN   20
`define LCC_BIT_ACCEPT_PHY    10
`define LCC_BIT_ACCEPT_SELFID 9
`define LCC_BIT_SYNC_FORCE    6
`define LCC_FLAG_RST          1'b0

// timer status layout
`define LCC_STAT_OFFSET_LSB   0
`define LCC_STAT_COUNT_LSB    12
`define LCC_STAT_ROOT_BIT     31

// timing: link tick rate against core clock rate, both in kHz
`define LCC_LINK_KHZ          24576
`define LCC_CORE_KHZ          50000
`define LCC_CYCLE_TICKS       3072

`endif

/* common/lcc_pkg.sv */
package lcc_pkg;
  typedef logic [7:0]  lcc_limit_t;
  typedef logic [11:0] lcc_offset_t;
  typedef logic [12:0] lcc_count_t;
endpackage

/* verilog/lcc_cycle_timer.sv */
`timescale 1ns/1ns
`include "lcc_map.svh"

module lcc_cycle_timer #(
  parameter int CYCLE_TICKS = `LCC_CYCLE_TICKS
) (
  input  wire logic               i_core_clk,
  input  wire logic               i_resetn,
  input  wire logic               i_tick,
  input  wire logic               i_run,
  input  wire logic               i_ext_select,
  input  wire logic               i_ext_event,
  input  wire logic               i_resync,
  output lcc_pkg::lcc_offset_t    o_offset,
  output lcc_pkg::lcc_count_t     o_count,
  output logic                    o_rollover
);

  localparam lcc_pkg::lcc_offset_t LAST = 12'(CYCLE_TICKS - 1);

  initial begin
    if (CYCLE_TICKS < 2 || CYCLE_TICKS > 4096) begin
      $error("cycle length does not fit the offset counter");
    end
  end

  lcc_pkg::lcc_offset_t offset_q;
  lcc_pkg::lcc_count_t  count_q;
  logic                 roll;

  // roll on own count or on external event, only while running
  always_comb begin
    if (!i_run) begin
      roll = 1'b0;
    end else if (i_ext_select) begin
      roll = i_ext_event;
    end else begin
      roll = i_tick && (offset_q == LAST);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      offset_q <= '0;
    end else if (i_resync || roll) begin
      offset_q <= '0;
    end else if (i_run && i_tick && offset_q != LAST) begin
      offset_q <= offset_q + 12'h001;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      count_q <= '0;
    end else if (roll) begin
      count_q <= count_q + 13'h0001;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_rollover <= 1'b0;
    end else begin
      o_rollover <= roll;
    end
  end

  assign o_offset = offset_q;
  assign o_count  = count_q;

endmodule

/* verilog/lcc_link_cycle_control.sv */
// Chosen here: the APB slave port.
`timescale 1ns/1ns
`include "lcc_map.svh"

module lcc_link_cycle_control #(
  parameter int N_ISO = 4
) (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_resetn,
  input  wire logic                 i_fundamental_reset_input_n,
  // apb slave
  input  wire logic                 i_psel,
  input  wire logic                 i_penable,
  input  wire logic                 i_pwrite,
  input  wire logic [7:0]           i_paddr,
  input  wire logic [31:0]          i_pwdata,
  output logic [31:0]               o_prdata,
  output logic                      o_pready,
  output logic                      o_pslverr,
  // fairness
  input  wire logic                 i_fairness_interval_start,
  input  wire logic                 i_prio_req,
  output logic                      o_prio_req_allowed,
  // cycle timer and cycle start
  input  wire logic                 i_external_cycle_input,
  input  wire logic                 i_overlong_cycle_event,
  input  wire logic                 i_cycle_start_rx,
  output logic                      o_cycle_start_accept,
  output logic                      o_cycle_start_emit,
  output lcc_pkg::lcc_offset_t      o_cycle_offset,
  // root status from phy
  input  wire logic                 i_bus_reset,
  input  wire logic                 i_phy_root,
  output logic                      o_root,
  // receiver
  input  wire logic                 i_async_receive_enabled,
  input  wire logic                 i_phy_pkt_rx,
  input  wire logic                 i_selfid_rx,
  output logic                      o_phy_pkt_store,
  output logic                      o_selfid_store,
  // isochronous receive match tag one bits
  input  wire logic [N_ISO-1:0]     i_tag_one_we,
  input  wire logic [N_ISO-1:0]     i_tag_one_wdata,
  output logic [N_ISO-1:0]          o_tag_one_sync_filter,
  // flag levels
  output logic                      o_external_rollover_select,
  output logic                      o_cycle_start_generate,
  output logic                      o_cycle_counter_run,
  output logic                      o_accept_phy_packets,
  output logic                      o_accept_selfid_packets,
  output logic                      o_sync_filter_force
);

  localparam logic [16:0] LINK_STEP = 17'(`LCC_LINK_KHZ);
  localparam logic [16:0] CORE_MOD  = 17'(`LCC_CORE_KHZ);

  initial begin
    if (N_ISO < 1 || N_ISO > 32) begin
      $error("iso context count out of range");
    end
    if (`LCC_LINK_KHZ >= `LCC_CORE_KHZ) begin
      $error("link tick rate must be below core clock rate");
    end
  end

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic hit_fair;
  logic hit_set;
  logic hit_clr;
  logic hit_stat;
  logic hit_any;
  logic wr_en;
  logic setup;

  assign hit_fair = (i_paddr == `LCC_OFS_FAIRNESS);
  assign hit_set  = (i_paddr == `LCC_OFS_LINK_SET);
  assign hit_clr  = (i_paddr == `LCC_OFS_LINK_CLEAR);
  assign hit_stat = (i_paddr == `LCC_OFS_TIMER_STATUS);
  assign hit_any  = hit_fair | hit_set | hit_clr | hit_stat;
  assign setup    = i_psel && !i_penable;
  assign wr_en    = i_psel && i_penable && i_pwrite;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit_any;

  logic set_wr;
  logic clr_wr;

  assign set_wr = wr_en && hit_set;
  assign clr_wr = wr_en && hit_clr;

  // ---------------------------------------------------------------
  // fairness limit
  // ---------------------------------------------------------------
  lcc_pkg::lcc_limit_t limit_q;
  lcc_pkg::lcc_limit_t used_q;

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      limit_q <= `LCC_FAIR_LIMIT_RST;
    end else if (wr_en && hit_fair) begin
      limit_q <= i_pwdata[`LCC_FAIR_LIMIT_LSB +: `LCC_FAIR_LIMIT_W];
    end
  end

  // a new interval frees the quota in the same cycle
  always_comb begin
    if (i_fairness_interval_start) begin
      o_prio_req_allowed = (limit_q != 8'h00);
    end else begin
      o_prio_req_allowed = (used_q < limit_q);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      used_q <= 8'h00;
    end else if (i_fairness_interval_start) begin
      used_q <= (i_prio_req && o_prio_req_allowed) ? 8'h01 : 8'h00;
    end else if (i_prio_req && o_prio_req_allowed) begin
      used_q <= used_q + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // link control flags
  // ---------------------------------------------------------------
  logic ext_sel_q;
  logic master_q;
  logic run_q;
  logic acc_phy_q;
  logic acc_sid_q;
  logic force_q;
  logic root_q;

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      ext_sel_q <= `LCC_FLAG_RST;
    end else if (set_wr && i_pwdata[`LCC_BIT_EXT_ROLLOVER]) begin
      ext_sel_q <= 1'b1;
    end else if (clr_wr && i_pwdata[`LCC_BIT_EXT_ROLLOVER]) begin
      ext_sel_q <= 1'b0;
    end
  end

  // hardware clear wins over a software set while the event stands
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      master_q <= `LCC_FLAG_RST;
    end else if (i_overlong_cycle_event) begin
      master_q <= 1'b0;
    end else if (set_wr && i_pwdata[`LCC_BIT_CYCLE_MASTER]) begin
      master_q <= 1'b1;
    end else if (clr_wr && i_pwdata[`LCC_BIT_CYCLE_MASTER]) begin
      master_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      run_q <= `LCC_FLAG_RST;
    end else if (set_wr && i_pwdata[`LCC_BIT_COUNTER_RUN]) begin
      run_q <= 1'b1;
    end else if (clr_wr && i_pwdata[`LCC_BIT_COUNTER_RUN]) begin
      run_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      acc_phy_q <= `LCC_FLAG_RST;
    end else if (set_wr && i_pwdata[`LCC_BIT_ACCEPT_PHY]) begin
      acc_phy_q <= 1'b1;
    end else if (clr_wr && i_pwdata[`LCC_BIT_ACCEPT_PHY]) begin
      acc_phy_q <= 1'b0;
    end
  end

  // software must have loaded the self-id pointer first
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      acc_sid_q <= `LCC_FLAG_RST;
    end else if (set_wr && i_pwdata[`LCC_BIT_ACCEPT_SELFID]) begin
      acc_sid_q <= 1'b1;
    end else if (clr_wr && i_pwdata[`LCC_BIT_ACCEPT_SELFID]) begin
      acc_sid_q <= 1'b0;
    end
  end

  // set only; clear address and system reset have no effect
  always_ff @(posedge i_core_clk) begin
    if (!i_fundamental_reset_input_n) begin
      force_q <= `LCC_FLAG_RST;
    end else if (set_wr && i_pwdata[`LCC_BIT_SYNC_FORCE]) begin
      force_q <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      root_q <= 1'b0;
    end else if (i_bus_reset) begin
      root_q <= i_phy_root;
    end
  end

  // ---------------------------------------------------------------
  // link tick from core clock, phase accumulator
  // ---------------------------------------------------------------
  logic [16:0] phase_q;
  logic [16:0] phase_sum;
  logic        tick;

  assign phase_sum = phase_q + LINK_STEP;
  assign tick      = (phase_sum >= CORE_MOD);

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      phase_q <= 17'h00000;
    end else if (tick) begin
      phase_q <= phase_sum - CORE_MOD;
    end else begin
      phase_q <= phase_sum;
    end
  end

  // ---------------------------------------------------------------
  // cycle timer and cycle start
  // ---------------------------------------------------------------
  lcc_pkg::lcc_offset_t offset;
  lcc_pkg::lcc_count_t  count;
  logic                 rollover;
  logic                 resync;

  assign resync = i_cycle_start_rx && !root_q;

  lcc_cycle_timer #(
    .CYCLE_TICKS (`LCC_CYCLE_TICKS)
  ) u_timer (
    .i_core_clk   (i_core_clk),
    .i_resetn     (i_resetn),
    .i_tick       (tick),
    .i_run        (run_q),
    .i_ext_select (ext_sel_q),
    .i_ext_event  (i_external_cycle_input),
    .i_resync     (resync),
    .o_offset     (offset),
    .o_count      (count),
    .o_rollover   (rollover)
  );

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_cycle_start_emit <= 1'b0;
    end else begin
      o_cycle_start_emit <= rollover && master_q && root_q;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_cycle_start_accept <= 1'b0;
    end else begin
      o_cycle_start_accept <= resync;
    end
  end

  assign o_cycle_offset = offset;

  // ---------------------------------------------------------------
  // receiver gating
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_phy_pkt_store <= 1'b0;
    end else begin
      o_phy_pkt_store <= i_phy_pkt_rx && acc_phy_q && i_async_receive_enabled;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_selfid_store <= 1'b0;
    end else begin
      o_selfid_store <= i_selfid_rx && acc_sid_q;
    end
  end

  // ---------------------------------------------------------------
  // per-context tag one sync filter bits
  // ---------------------------------------------------------------
  logic [N_ISO-1:0] tag_q;

  for (genvar g = 0; g < N_ISO; g++) begin : g_iso
    always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
        tag_q[g] <= 1'b0;
      end else if (i_tag_one_we[g]) begin
        tag_q[g] <= i_tag_one_wdata[g];
      end
    end
    assign o_tag_one_sync_filter[g] = tag_q[g] | force_q;
  end

  // ---------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------
  logic [31:0] flags;
  logic [31:0] rd_mux;

  always_comb begin
    flags = 32'h00000000;
    flags[`LCC_BIT_EXT_ROLLOVER]  = ext_sel_q;
    flags[`LCC_BIT_CYCLE_MASTER]  = master_q;
    flags[`LCC_BIT_COUNTER_RUN]   = run_q;
    flags[`LCC_BIT_ACCEPT_PHY]    = acc_phy_q;
    flags[`LCC_BIT_ACCEPT_SELFID] = acc_sid_q;
    flags[`LCC_BIT_SYNC_FORCE]    = force_q;
  end

  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_fair) begin
      rd_mux = {24'h000000, limit_q};
    end else if (hit_set || hit_clr) begin
      rd_mux = flags;
    end else if (hit_stat) begin
      rd_mux[`LCC_STAT_OFFSET_LSB +: 12] = offset;
      rd_mux[`LCC_STAT_COUNT_LSB +: 13]  = count;
      rd_mux[`LCC_STAT_ROOT_BIT]         = root_q;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_prdata <= 32'h00000000;
    end else if (setup && !i_pwrite) begin
      o_prdata <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // flag levels out
  // ---------------------------------------------------------------
  assign o_external_rollover_select = ext_sel_q;
  assign o_cycle_start_generate     = master_q;
  assign o_cycle_counter_run        = run_q;
  assign o_accept_phy_packets       = acc_phy_q;
  assign o_accept_selfid_packets    = acc_sid_q;
  assign o_sync_filter_force        = force_q;
  assign o_root                     = root_q;

endmodule

/* tb/lcc_link_cycle_control_monitor.sv */
`timescale 1ns/1ns
module lcc_link_cycle_control_monitor #(
  parameter int N_ISO = 4
) (
  input wire logic             i_core_clk,
  input wire logic             i_resetn,
  input wire logic             i_fundamental_reset_input_n,
  input wire logic             i_psel,
  input wire logic             i_penable,
  input wire logic             i_pwrite,
  input wire logic [7:0]       i_paddr,
  input wire logic [31:0]      i_pwdata,
  input wire logic             o_pslverr,
  input wire logic             i_fairness_interval_start,
  input wire logic             i_prio_req,
  input wire logic             o_prio_req_allowed,
  input wire logic             i_overlong_cycle_event,
  input wire logic             i_cycle_start_rx,
  input wire logic             o_cycle_start_accept,
  input wire logic             o_cycle_start_emit,
  input lcc_pkg::lcc_offset_t  o_cycle_offset,
  input wire logic             i_bus_reset,
  input wire logic             i_phy_root,
  input wire logic             o_root,
  input wire logic             i_async_receive_enabled,
  input wire logic             i_phy_pkt_rx,
  input wire logic             i_selfid_rx,
  input wire logic             o_phy_pkt_store,
  input wire logic             o_selfid_store,
  input wire logic [N_ISO-1:0] o_tag_one_sync_filter,
  input wire logic             o_cycle_start_generate,
  input wire logic             o_cycle_counter_run,
  input wire logic             o_accept_phy_packets,
  input wire logic             o_accept_selfid_packets,
  input wire logic             o_sync_filter_force
);
  logic [7:0] lim_q;
  logic [8:0] used_q;
  logic       grant;
  logic       mapped;
  assign grant = i_prio_req & o_prio_req_allowed;
  assign mapped = i_paddr inside {8'hdc, 8'he0, 8'he4, 8'hf0};
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) lim_q <= 8'h00;
    else if (i_psel && i_penable && i_pwrite && i_paddr == 8'hdc) lim_q <= i_pwdata[7:0];
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn || i_fairness_interval_start) used_q <= {8'h00, grant};
    else used_q <= used_q + {8'h00, grant};
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  fair_limit_a: assert property (grant |-> (i_fairness_interval_start ? 9'h000 : used_q) < {1'b0, lim_q})
    else $error("priority request granted beyond limit");
  self_id_a: assert property (o_selfid_store == $past(i_selfid_rx & o_accept_selfid_packets))
    else $error("self-id store mismatch");
  phy_pkt_a: assert property (o_phy_pkt_store == $past(i_phy_pkt_rx & o_accept_phy_packets & i_async_receive_enabled))
    else $error("phy packet store mismatch");
  emit_at_roll_a: assert property (o_cycle_start_emit |-> o_cycle_offset <= 12'h002 && o_root)
    else $error("cycle start away from rollover");
  accept_start_a: assert property (i_cycle_start_rx |=> o_cycle_start_accept == !$past(o_root))
    else $error("cycle start accept wrong");
  offset_hold_a: assert property (!o_cycle_counter_run && !i_cycle_start_rx |=> $stable(o_cycle_offset))
    else $error("offset moved while stopped");
  overlong_clr_a: assert property (i_overlong_cycle_event |=> !o_cycle_start_generate)
    else $error("master flag kept during overlong");
  root_load_a: assert property (i_bus_reset |=> o_root == $past(i_phy_root))
    else $error("root not loaded");
  force_tags_a: assert property (o_sync_filter_force |-> &o_tag_one_sync_filter)
    else $error("tag bits not forced");
  force_keep_a: assert property (o_sync_filter_force && i_fundamental_reset_input_n |=> o_sync_filter_force)
    else $error("force cleared without reset");
  unmapped_err_a: assert property (i_psel && i_penable |-> o_pslverr == !mapped)
    else $error("slave error wrong");
endmodule
bind lcc_link_cycle_control lcc_link_cycle_control_monitor #(.N_ISO(N_ISO)) mon (.i_core_clk, .i_resetn,
  .i_fundamental_reset_input_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pslverr,
  .i_fairness_interval_start, .i_prio_req, .o_prio_req_allowed, .i_overlong_cycle_event, .i_cycle_start_rx,
  .o_cycle_start_accept, .o_cycle_start_emit, .o_cycle_offset, .i_bus_reset, .i_phy_root, .o_root,
  .i_async_receive_enabled, .i_phy_pkt_rx, .i_selfid_rx, .o_phy_pkt_store, .o_selfid_store,
  .o_tag_one_sync_filter, .o_cycle_start_generate, .o_cycle_counter_run, .o_accept_phy_packets,
  .o_accept_selfid_packets, .o_sync_filter_force);

/* tb/lcc_phy_model.sv */
`timescale 1ns/1ns
module lcc_phy_model (
  input  wire logic i_core_clk,
  output logic      o_bus_reset,
  output logic      o_phy_root,
  output logic [3:0] o_ev
);
  initial begin
    o_bus_reset = 1'b0;
    o_phy_root = 1'b0;
    o_ev = 4'h0;
  end
  // root status reported while bus reset runs, for len cycles
  task automatic bus_reset(input logic root, input int len);
    @(posedge i_core_clk);
    o_bus_reset <= 1'b1;
    o_phy_root <= root;
    repeat (len) @(posedge i_core_clk);
    o_bus_reset <= 1'b0;
    o_phy_root <= ~root;
  endtask
  // one-cycle event: 0 cycle start, 1 phy packet, 2 self-id, 3 external cycle
  task automatic pulse(input int k);
    @(posedge i_core_clk);
    o_ev <= 4'h1 << k;
    @(posedge i_core_clk);
    o_ev <= 4'h0;
  endtask
endmodule

/* tb/lcc_link_cycle_control_test.sv */
`timescale 1ns/1ns
module lcc_link_cycle_control_test;
  logic i_core_clk = 0, i_resetn = 0, i_fundamental_reset_input_n = 0;
  logic i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata;
  logic o_pready, o_pslverr, i_fairness_interval_start = 0, i_prio_req = 0, o_prio_req_allowed;
  logic i_overlong_cycle_event = 0, o_cycle_start_accept, o_cycle_start_emit, i_bus_reset, i_phy_root, o_root;
  logic i_async_receive_enabled = 0, o_phy_pkt_store, o_selfid_store, o_external_rollover_select;
  logic o_cycle_start_generate, o_cycle_counter_run, o_accept_phy_packets, o_accept_selfid_packets;
  logic o_sync_filter_force;
  logic [3:0] ev, i_tag_one_we = 0, i_tag_one_wdata = 0, o_tag_one_sync_filter;
  logic i_external_cycle_input, i_cycle_start_rx, i_phy_pkt_rx, i_selfid_rx;
  lcc_pkg::lcc_offset_t o_cycle_offset;
  int n_errors = 0, checks = 0;
  assign {i_external_cycle_input, i_selfid_rx, i_phy_pkt_rx, i_cycle_start_rx} = ev;
  lcc_link_cycle_control dut (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_fundamental_reset_input_n(i_fundamental_reset_input_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_fairness_interval_start(i_fairness_interval_start), .i_prio_req(i_prio_req),
    .o_prio_req_allowed(o_prio_req_allowed), .i_external_cycle_input(i_external_cycle_input),
    .i_overlong_cycle_event(i_overlong_cycle_event), .i_cycle_start_rx(i_cycle_start_rx),
    .o_cycle_start_accept(o_cycle_start_accept), .o_cycle_start_emit(o_cycle_start_emit),
    .o_cycle_offset(o_cycle_offset), .i_bus_reset(i_bus_reset), .i_phy_root(i_phy_root), .o_root(o_root),
    .i_async_receive_enabled(i_async_receive_enabled), .i_phy_pkt_rx(i_phy_pkt_rx), .i_selfid_rx(i_selfid_rx),
    .o_phy_pkt_store(o_phy_pkt_store), .o_selfid_store(o_selfid_store), .i_tag_one_we(i_tag_one_we),
    .i_tag_one_wdata(i_tag_one_wdata), .o_tag_one_sync_filter(o_tag_one_sync_filter),
    .o_external_rollover_select(o_external_rollover_select), .o_cycle_start_generate(o_cycle_start_generate),
    .o_cycle_counter_run(o_cycle_counter_run), .o_accept_phy_packets(o_accept_phy_packets),
    .o_accept_selfid_packets(o_accept_selfid_packets), .o_sync_filter_force(o_sync_filter_force));
  lcc_phy_model ph (.i_core_clk, .o_bus_reset(i_bus_reset), .o_phy_root(i_phy_root), .o_ev(ev));
  initial forever #10 i_core_clk = ~i_core_clk;
  task automatic final_report;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic err);
    int n;
    n = 0;
    @(posedge i_core_clk);
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1;
    do begin
      @(posedge i_core_clk);
      if (++n > 20) begin
        n_errors++;
        final_report();
      end
    end while (o_pready !== 1'b1);
    r = o_prdata;
    err = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic wait_emit(input int lim, output int n);
    n = 0;
    do begin
      @(posedge i_core_clk);
      if (++n > lim) begin
        n_errors++;
        final_report();
      end
    end while (o_cycle_start_emit !== 1'b1);
  endtask
  task automatic ev_chk(input int k, input logic x);
    ph.pulse(k);
    @(posedge i_core_clk);
    chk({31'h0, k == 1 ? o_phy_pkt_store : o_selfid_store}, {31'h0, x});
  endtask
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    rd(8'hdc, 32'h0);
    rd(8'he0, 32'h0);
    wr(8'hdc, 32'hffffffff);
    rd(8'hdc, 32'h000000ff);
    wr(8'he0, 32'hffffffff);
    rd(8'he4, 32'h00700640);
    wr(8'he4, 32'hffffffff);
    rd(8'he0, 32'h00000040);
    apb(0, 8'h10, 32'h0, r, e);
    chk({r[31:1], e}, 32'h1);
    $display("regs done");
  endtask
  task automatic fair(input logic [7:0] lim, input int x);
    int g;
    g = 0;
    wr(8'hdc, {24'h0, lim});
    i_fairness_interval_start <= 1;
    i_prio_req <= 1;
    repeat (5) begin
      @(posedge i_core_clk);
      i_fairness_interval_start <= 0;
      g += (o_prio_req_allowed === 1'b1);
    end
    i_prio_req <= 0;
    chk(g, x);
  endtask
  task automatic t_rx;
    wr(8'he0, 32'h00000600);
    i_async_receive_enabled <= 1;
    ev_chk(1, 1);
    ev_chk(2, 1);
    wr(8'he4, 32'h00000200);
    ev_chk(2, 0);
    i_async_receive_enabled <= 0;
    ev_chk(1, 0);
    $display("rx done");
  endtask
  task automatic t_cycle;
    int n;
    lcc_pkg::lcc_offset_t o;
    ph.bus_reset(1, 3);
    chk(o_root, 1);
    wr(8'he0, 32'h00300000);
    wait_emit(7000, n);
    wait_emit(7000, n);
    chk(n inside {[6249:6251]}, 1);
    i_overlong_cycle_event <= 1;
    wr(8'he0, 32'h00200000);
    i_overlong_cycle_event <= 0;
    rd(8'he0, 32'h00100440);
    wr(8'he0, 32'h00600000);
    n = 0;
    repeat (7000) begin
      @(posedge i_core_clk);
      n += (o_cycle_start_emit === 1'b1);
    end
    chk(n, 0);
    chk(o_external_rollover_select, 1);
    ph.pulse(3);
    wait_emit(3, n);
    wr(8'he4, 32'h00100000);
    @(posedge i_core_clk);
    chk(o_cycle_counter_run, 0);
    o = o_cycle_offset;
    repeat (50) @(posedge i_core_clk);
    chk(o_cycle_offset, o);
    ph.bus_reset(0, 1);
    ph.pulse(0);
    @(posedge i_core_clk);
    chk(o_cycle_start_accept, 1);
    $display("cycle done");
  endtask
  task automatic t_force;
    i_fundamental_reset_input_n <= 0;
    @(posedge i_core_clk);
    i_fundamental_reset_input_n <= 1;
    i_tag_one_we <= 4'hf;
    @(posedge i_core_clk);
    i_tag_one_we <= 4'h0;
    @(posedge i_core_clk);
    chk(o_tag_one_sync_filter, 4'h0);
    wr(8'he0, 32'h00000040);
    @(posedge i_core_clk);
    chk(o_tag_one_sync_filter, 4'hf);
    wr(8'he4, 32'h00000040);
    i_resetn <= 0;
    @(posedge i_core_clk);
    i_resetn <= 1;
    @(posedge i_core_clk);
    chk(o_sync_filter_force, 1);
    $display("force done");
  endtask
  initial begin
    repeat (3) @(posedge i_core_clk);
    i_resetn <= 1;
    i_fundamental_reset_input_n <= 1;
    t_regs();
    fair(8'h02, 2);
    fair(8'h00, 0);
    fair(8'h03, 3);
    $display("fair done");
    t_rx();
    t_cycle();
    t_force();
    final_report();
  end
endmodule
